// ### src/lpm_consts.svh
// constants for the low-power mode sequencer
// Operation
// [R1] wait-for-event with deep-sleep select set enters backup state
// [R2] backup keeps backup domain and slow oscillator; regulator and core supply off
// [R3] any enabled wake event (pins 0-15, supply monitor, calendar, timer) leaves backup
// [R4] regulator returns to normal within 100 us after backup exit
// [R5] wait state stops core, peripheral and memory clocks, supplies stay on
// [R6] wait-for-event with low-power select set enters wait state
// [R7] fast-startup pins, calendar, timer or USB wake resume from wait
// [R8] restart from wait completes within 10 us
// [R9] software picks fast RC clock, sets low-power select, then waits for event
// [R10] fast RC enable flag cleared on wait entry, set again on exit
// [R11] wait entry only after resynchronisation cycles since the flag changed
// [R12] software should poll the fast RC enable flag until it clears
// [R13] active core clock from fast RC, crystal or first PLL
// [R14] regulator disable is a separate software control from backup
// [R15] software selects RC or crystal as the 32 kHz source
// [R16] I/O states held in backup; after backup reset inputs with pull-ups
// [R17] backup wake re-enables core and SRAM supplies if off
// [R18] fast startup restarts fast RC, selects 4 MHz RC, re-enables core clock
// [R19] a wake already pending at wait-for-event aborts entry
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH
`define CLK_PERIOD_NS     10
`define NS_PER_US         1000
`define REG_START_US      100
`define WAIT_RESTART_US   10
`define RESYNC_CYCLES     4
`define CLKSRC_FAST_RC    2'h0
`define CLKSRC_CRYSTAL    2'h1
`define CLKSRC_PLL        2'h2
`define CLKSRC_WIDTH      2
`endif

// ### src/lpm_pkg.sv
// types for the low-power mode sequencer
package lpm_pkg;
    typedef enum logic [2:0] {
        ST_ACTIVE    = 3'b000,
        ST_RESYNC    = 3'b001,
        ST_WAIT      = 3'b010,
        ST_WAIT_EXIT = 3'b011,
        ST_BACKUP    = 3'b100,
        ST_BK_EXIT   = 3'b101
    } lpm_state_t;
endpackage

// ### src/wake_edge_detect.sv
// per-pin transition detector with optional debounce for wake pins
`timescale 1ns/1ns
module wake_edge_detect #(
    parameter int N     = 16,
    parameter int DEB_W = 4
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] pins,
    input  wire logic [N-1:0] enables,
    input  wire logic [N-1:0] debounce_en,
    input  wire logic         armed,
    output logic      [N-1:0] hit
);
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic             stable_r;
            logic             stable_nxt;
            logic [DEB_W-1:0] cnt_r;
            logic [DEB_W-1:0] cnt_nxt;
            logic             hit_r;
            logic             hit_nxt;
            always_comb begin
                stable_nxt = stable_r;
                cnt_nxt    = '0;
                hit_nxt    = 1'b0;
                if (pins[g] != stable_r) begin
                    cnt_nxt = cnt_r + 1'b1;
                    // debounce waits for the counter to fill before accepting a change
                    if (!debounce_en[g] || (&cnt_r)) begin
                        stable_nxt = pins[g];
                        cnt_nxt    = '0;
                        hit_nxt    = enables[g] & armed; // [R3]
                    end
                end
            end
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    stable_r <= 1'b0;
                    cnt_r    <= '0;
                    hit_r    <= 1'b0;
                end else begin
                    stable_r <= stable_nxt;
                    cnt_r    <= cnt_nxt;
                    hit_r    <= hit_nxt;
                end
            end
            assign hit[g] = hit_r;
        end
    endgenerate
endmodule // wake_edge_detect

// ### src/low_power_mode_sequencer.sv
// low-power mode sequencer: active, wait and backup states
`timescale 1ns/1ns
`include "lpm_consts.svh"
module low_power_mode_sequencer
    import lpm_pkg::*;
#(
    parameter int N_WAKE        = 16,
    parameter int DEB_W         = 4,
    parameter int REG_START_CYC = (`REG_START_US * `NS_PER_US) / `CLK_PERIOD_NS
) (
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              wait_for_event_instr,
    input  wire logic              deep_sleep_select,
    input  wire logic              low_power_select,
    input  wire logic [1:0]        main_clk_select,
    input  wire logic              reg_disable,
    input  wire logic              slow_clk_xtal_sel,
    input  wire logic [N_WAKE-1:0] wake_pins,
    input  wire logic [N_WAKE-1:0] wake_pin_enables,
    input  wire logic [N_WAKE-1:0] wake_pin_debounce,
    input  wire logic [N_WAKE-1:0] fast_startup_enables,
    input  wire logic              supply_monitor_alarm,
    input  wire logic              supply_monitor_wake_en,
    input  wire logic              calendar_alarm,
    input  wire logic              calendar_wake_en,
    input  wire logic              real_time_timer_alarm,
    input  wire logic              real_time_timer_wake_en,
    input  wire logic              usb_wake,
    input  wire logic              usb_wake_en,
    output logic                   fast_rc_osc_enable,
    output logic [1:0]             core_clk_source,
    output logic                   core_clk_en,
    output logic                   periph_clk_en,
    output logic                   mem_clk_en,
    output logic                   regulator_on,
    output logic                   regulator_ready,
    output logic                   core_supply_on,
    output logic                   sram_supply_on,
    output logic                   backup_domain_on,
    output logic                   slow_osc_xtal,
    output logic                   io_hold,
    output logic                   io_reset_pullup,
    output logic                   in_wait,
    output logic                   in_backup
);
    localparam int WAIT_CYC = (`WAIT_RESTART_US * `NS_PER_US) / `CLK_PERIOD_NS;
    localparam int CNT_W    = $clog2(REG_START_CYC + 1);

    logic rs1_r;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    lpm_state_t        state_r;
    lpm_state_t        state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic              rc_en_r;
    logic              rc_en_nxt;
    logic [1:0]        clksrc_r;
    logic [1:0]        clksrc_nxt;
    logic              clk_on_r;
    logic              clk_on_nxt;
    logic              reg_on_r;
    logic              reg_on_nxt;
    logic              reg_rdy_r;
    logic              reg_rdy_nxt;
    logic              supply_r;
    logic              supply_nxt;
    logic              hold_r;
    logic              hold_nxt;
    logic              pullup_r;
    logic              pullup_nxt;
    logic              xtal_r;
    logic [N_WAKE-1:0] pin_hit;
    logic              bk_wake;
    logic              fs_wake;
    logic              armed;

    assign armed = (state_r == ST_BACKUP) || (state_r == ST_RESYNC && deep_sleep_select);

    wake_edge_detect #(
        .N     (N_WAKE),
        .DEB_W (DEB_W)
    ) u_wake (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .pins        (wake_pins),
        .enables     (wake_pin_enables),
        .debounce_en (wake_pin_debounce),
        .armed       (armed),
        .hit         (pin_hit)
    );

    // backup wake sources are level alarms plus pin transitions
    assign bk_wake = (|pin_hit) | (supply_monitor_alarm & supply_monitor_wake_en)
                   | (calendar_alarm & calendar_wake_en)
                   | (real_time_timer_alarm & real_time_timer_wake_en); // [R3]
    // fast startup asserts on a low level of an enabled pin
    assign fs_wake = (|(~wake_pins & fast_startup_enables))
                   | (calendar_alarm & calendar_wake_en)
                   | (real_time_timer_alarm & real_time_timer_wake_en)
                   | (usb_wake & usb_wake_en); // [R7]

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        rc_en_nxt   = rc_en_r;
        clksrc_nxt  = main_clk_select; // [R13]
        clk_on_nxt  = clk_on_r;
        reg_on_nxt  = !reg_disable; // [R14]
        reg_rdy_nxt = reg_rdy_r;
        supply_nxt  = supply_r;
        hold_nxt    = hold_r;
        pullup_nxt  = pullup_r;
        case (state_r)
            ST_ACTIVE: begin
                // a pending wake at entry keeps the device running
                // pull-ups from the last reset stay on until the next low-power entry
                if (wait_for_event_instr && deep_sleep_select && !bk_wake) begin // [R1] [R19]
                    state_nxt  = ST_RESYNC;
                    cnt_nxt    = '0;
                    pullup_nxt = 1'b0; // [R16]
                end else if (wait_for_event_instr && low_power_select
                             && !fs_wake) begin // [R6] [R19]
                    state_nxt  = ST_RESYNC;
                    cnt_nxt    = '0;
                    rc_en_nxt  = 1'b0; // [R10]
                    pullup_nxt = 1'b0; // [R16]
                end
            end
            ST_RESYNC: begin
                // entry only after the flag write has resynchronised
                cnt_nxt = cnt_r + 1'b1;
                if ((deep_sleep_select && bk_wake) || (!deep_sleep_select && fs_wake)) begin
                    state_nxt = ST_ACTIVE; // [R19]
                    rc_en_nxt = 1'b1;
                end else if (cnt_r == CNT_W'(`RESYNC_CYCLES - 1)) begin // [R11]
                    if (deep_sleep_select) begin
                        state_nxt  = ST_BACKUP;
                        hold_nxt   = 1'b1; // [R16]
                        supply_nxt = 1'b0; // [R2]
                        reg_on_nxt = 1'b0; // [R2]
                    end else begin
                        state_nxt = ST_WAIT;
                    end
                    clk_on_nxt = 1'b0; // [R5]
                end
            end
            ST_WAIT: begin
                clksrc_nxt = `CLKSRC_FAST_RC;
                if (fs_wake) begin // [R7]
                    state_nxt = ST_WAIT_EXIT;
                    rc_en_nxt = 1'b1; // [R10] [R18]
                    cnt_nxt   = '0;
                end
            end
            ST_WAIT_EXIT: begin
                clksrc_nxt = `CLKSRC_FAST_RC; // [R18]
                cnt_nxt    = cnt_r + 1'b1;
                // core clock returns well inside the restart budget
                if (cnt_r == CNT_W'(`RESYNC_CYCLES - 1) || cnt_r == CNT_W'(WAIT_CYC - 1)) begin
                    state_nxt  = ST_ACTIVE; // [R8]
                    clk_on_nxt = 1'b1; // [R18]
                end
            end
            ST_BACKUP: begin
                reg_on_nxt  = 1'b0; // [R2]
                reg_rdy_nxt = 1'b0;
                if (bk_wake) begin // [R3]
                    state_nxt  = ST_BK_EXIT;
                    supply_nxt = 1'b1; // [R17]
                    cnt_nxt    = '0;
                end
            end
            ST_BK_EXIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == CNT_W'(REG_START_CYC - 1)) begin // [R4]
                    state_nxt   = ST_ACTIVE;
                    reg_rdy_nxt = 1'b1;
                    clk_on_nxt  = 1'b1;
                    hold_nxt    = 1'b0;
                    pullup_nxt  = 1'b1; // [R16]
                    rc_en_nxt   = 1'b1;
                    clksrc_nxt  = `CLKSRC_FAST_RC;
                end
            end
            default: state_nxt = ST_ACTIVE;
        endcase
        if (state_nxt == ST_ACTIVE && state_r != ST_ACTIVE && !reg_on_nxt)
            reg_rdy_nxt = 1'b0;
        else if (state_r == ST_ACTIVE)
            reg_rdy_nxt = reg_on_nxt;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_ACTIVE;
            cnt_r     <= '0;
            rc_en_r   <= 1'b1;
            clksrc_r  <= `CLKSRC_FAST_RC;
            clk_on_r  <= 1'b1;
            reg_on_r  <= 1'b1;
            reg_rdy_r <= 1'b1;
            supply_r  <= 1'b1;
            hold_r    <= 1'b0;
            pullup_r  <= 1'b1;
            xtal_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            rc_en_r   <= rc_en_nxt;
            clksrc_r  <= clksrc_nxt;
            clk_on_r  <= clk_on_nxt;
            reg_on_r  <= reg_on_nxt;
            reg_rdy_r <= reg_rdy_nxt;
            supply_r  <= supply_nxt;
            hold_r    <= hold_nxt;
            pullup_r  <= pullup_nxt;
            xtal_r    <= slow_clk_xtal_sel; // [R15]
        end
    end

    // the backup domain never powers down, so it is a constant flop
    logic bk_on_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            bk_on_r <= 1'b1;
        else
            bk_on_r <= 1'b1; // [R2]
    end

    logic in_wait_r;
    logic in_backup_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_wait_r   <= 1'b0;
            in_backup_r <= 1'b0;
        end else begin
            in_wait_r   <= (state_nxt == ST_WAIT);
            in_backup_r <= (state_nxt == ST_BACKUP);
        end
    end

    assign fast_rc_osc_enable = rc_en_r;
    assign core_clk_source    = clksrc_r;
    assign core_clk_en        = clk_on_r;
    assign periph_clk_en      = clk_on_r;
    assign mem_clk_en         = clk_on_r;
    assign regulator_on       = reg_on_r;
    assign regulator_ready    = reg_rdy_r;
    assign core_supply_on     = supply_r;
    assign sram_supply_on     = supply_r;
    assign backup_domain_on   = bk_on_r;
    assign slow_osc_xtal      = xtal_r;
    assign io_hold            = hold_r;
    assign io_reset_pullup    = pullup_r;
    assign in_wait            = in_wait_r;
    assign in_backup          = in_backup_r;
endmodule // low_power_mode_sequencer

// ### verif/lpm_checker.sv
// concurrent checks on the low-power mode sequencer ports
`timescale 1ns/1ns
`include "lpm_consts.svh"
module lpm_checker #(
    parameter int REG_START_CYC = 10000
) (
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       wait_for_event_instr,
    input wire logic       deep_sleep_select,
    input wire logic       low_power_select,
    input wire logic [1:0] main_clk_select,
    input wire logic       reg_disable,
    input wire logic       slow_clk_xtal_sel,
    input wire logic       fast_rc_osc_enable,
    input wire logic [1:0] core_clk_source,
    input wire logic       core_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       mem_clk_en,
    input wire logic       regulator_on,
    input wire logic       regulator_ready,
    input wire logic       core_supply_on,
    input wire logic       sram_supply_on,
    input wire logic       backup_domain_on,
    input wire logic       slow_osc_xtal,
    input wire logic       io_hold,
    input wire logic       io_reset_pullup,
    input wire logic       in_wait,
    input wire logic       in_backup
);
    localparam int REG_BOUND = REG_START_CYC + 3;
    logic [2:0] rst_sync_r;
    logic [2:0] rst_sync_nxt;
    // extend the design's two-flop reset synchroniser by one stage so checks start a cycle after its registers
    always_comb rst_sync_nxt = {rst_sync_r[1:0], 1'b1};
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) rst_sync_r <= 3'h0;
        else rst_sync_r <= rst_sync_nxt;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_r[2]);

    // cycles the regulator has been on without reporting ready
    logic [15:0] up_cnt_r;
    logic [15:0] up_cnt_nxt;
    always_comb up_cnt_nxt = (regulator_on && !regulator_ready) ? up_cnt_r + 16'h1 : 16'h0;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) up_cnt_r <= 16'h0;
        else up_cnt_r <= up_cnt_nxt;
    end

    property p_wait_entry;
        $rose(in_wait) |-> $past(wait_for_event_instr, 5) && $past(low_power_select, 5)
            && !$past(deep_sleep_select, 5);
    endproperty
    property p_backup_entry;
        $rose(in_backup) |-> $past(wait_for_event_instr, 5) && $past(deep_sleep_select, 5);
    endproperty
    property p_resync;
        $rose(in_wait) |-> !$past(fast_rc_osc_enable, 4) && !fast_rc_osc_enable;
    endproperty
    property p_wait_power;
        in_wait |-> !core_clk_en && !periph_clk_en && !mem_clk_en && core_supply_on
            && sram_supply_on;
    endproperty
    property p_wait_exit;
        $fell(in_wait) |-> (fast_rc_osc_enable && !core_clk_en) [*4]
            ##1 (core_clk_en && core_clk_source == `CLKSRC_FAST_RC);
    endproperty
    property p_backup_power;
        in_backup |-> !regulator_on && !core_supply_on && !sram_supply_on
            && backup_domain_on && io_hold;
    endproperty
    property p_backup_exit;
        $fell(in_backup) |-> !regulator_ready ##[0:1] (core_supply_on && sram_supply_on);
    endproperty
    property p_reg_start;
        regulator_on && !regulator_ready |-> up_cnt_r < REG_BOUND;
    endproperty
    property p_io_release;
        $fell(io_hold) |-> io_reset_pullup;
    endproperty
    property p_reg_disable;
        core_clk_en ##1 (core_clk_en && $stable(reg_disable)) |-> regulator_on == !reg_disable;
    endproperty
    property p_slow_src;
        slow_osc_xtal == $past(slow_clk_xtal_sel);
    endproperty
    property p_clk_src;
        core_clk_en ##1 (core_clk_en && $stable(main_clk_select))
            |-> core_clk_source == main_clk_select;
    endproperty

    a_wait_entry:   assert property (p_wait_entry)
        else $error("wait entered without request");
    a_backup_entry: assert property (p_backup_entry)
        else $error("backup without request");
    a_resync:       assert property (p_resync)
        else $error("wait entry before resync");
    a_wait_power:   assert property (p_wait_power)
        else $error("wait clocks or supplies wrong");
    a_wait_exit:    assert property (p_wait_exit)
        else $error("wait restart sequence wrong");
    a_backup_power: assert property (p_backup_power)
        else $error("backup power wrong");
    a_backup_exit:  assert property (p_backup_exit)
        else $error("supplies not restored");
    a_reg_start:    assert property (p_reg_start)
        else $error("regulator start late");
    a_io_release:   assert property (p_io_release)
        else $error("io released without pull-ups");
    a_reg_disable:  assert property (p_reg_disable)
        else $error("regulator disable ignored");
    a_slow_src:     assert property (p_slow_src)
        else $error("slow clock source wrong");
    a_clk_src:      assert property (p_clk_src)
        else $error("core clock source wrong");

    c_wait:      cover property ($rose(in_wait));
    c_wait_out:  cover property ($fell(in_wait));
    c_backup:    cover property ($fell(in_backup));
endmodule // lpm_checker

bind low_power_mode_sequencer lpm_checker #(.REG_START_CYC(REG_START_CYC)) i_lpm_checker (
    .sys_clk, .arst_n, .wait_for_event_instr, .deep_sleep_select, .low_power_select,
    .main_clk_select, .reg_disable, .slow_clk_xtal_sel, .fast_rc_osc_enable, .core_clk_source,
    .core_clk_en, .periph_clk_en, .mem_clk_en, .regulator_on, .regulator_ready,
    .core_supply_on, .sram_supply_on, .backup_domain_on, .slow_osc_xtal, .io_hold,
    .io_reset_pullup, .in_wait, .in_backup);

// ### verif/core_model.sv
// processor-side model: clock choice, mode select and wait-for-event pulse
`timescale 1ns/1ns
`include "lpm_consts.svh"
module core_model (
    input  wire logic       sys_clk,
    input  wire logic       fast_rc_osc_enable,
    output logic            wait_for_event_instr,
    output logic            deep_sleep_select,
    output logic            low_power_select,
    output logic [1:0]      main_clk_select
);
    initial begin
        wait_for_event_instr = 1'b0;
        deep_sleep_select    = 1'b0;
        low_power_select     = 1'b0;
        main_clk_select      = `CLKSRC_FAST_RC;
    end
    task automatic set_clk(input logic [1:0] v);
        @(negedge sys_clk);
        main_clk_select = v;
    endtask
    task automatic sleep(input logic deep, output int n);
        set_clk(`CLKSRC_FAST_RC);
        @(negedge sys_clk);
        low_power_select  = 1'b1;
        deep_sleep_select = deep;
        @(negedge sys_clk);
        wait_for_event_instr = 1'b1;
        @(negedge sys_clk);
        wait_for_event_instr = 1'b0;
        n = 0;
        // bounded so that an aborted entry cannot stall the core forever
        while (!deep && n < 8 && fast_rc_osc_enable !== 1'b0) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
endmodule // core_model

// ### verif/low_power_mode_sequencer_bench.sv
// self-checking bench for the low-power mode sequencer
`timescale 1ns/1ns
`include "lpm_consts.svh"
module low_power_mode_sequencer_bench;
    localparam int REG_CYC = 20;
    logic        sys_clk, arst_n, wait_for_event_instr, deep_sleep_select, low_power_select;
    logic        reg_disable, slow_clk_xtal_sel, supply_monitor_alarm, supply_monitor_wake_en;
    logic        calendar_alarm, calendar_wake_en, real_time_timer_alarm, real_time_timer_wake_en;
    logic        usb_wake, usb_wake_en, fast_rc_osc_enable, core_clk_en, periph_clk_en, mem_clk_en;
    logic        regulator_on, regulator_ready, core_supply_on, sram_supply_on, backup_domain_on;
    logic        slow_osc_xtal, io_hold, io_reset_pullup, in_wait, in_backup;
    logic [1:0]  main_clk_select, core_clk_source;
    logic [15:0] wake_pins, wake_pin_enables, wake_pin_debounce, fast_startup_enables;
    logic [3:0]  obs;
    int          mismatches, tests_run, n, s;
    int          bk_src[4] = '{1, 2, 4, 5};
    assign obs = {regulator_ready, core_clk_en, in_backup, in_wait};

    low_power_mode_sequencer #(.REG_START_CYC(REG_CYC)) i_low_power_mode_sequencer (.*);
    core_model i_core_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic summarize;
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // obs index: 0 wait, 1 backup, 2 core clock, 3 regulator ready
    task automatic wait_on(input int idx, input logic v, input int lim, output int cnt);
        for (cnt = 0; cnt < lim && obs[idx] !== v; cnt++) @(negedge sys_clk);
        if (obs[idx] !== v) begin
            mismatches++;
            $display("CHECK FAILED at %0t: timeout on %0d", $time, idx);
            summarize();
        end
    endtask
    task automatic wake(input int src, input logic v);
        @(negedge sys_clk);
        case (src)
            0: fast_startup_enables[5] = v;
            1: calendar_alarm = v;
            2: real_time_timer_alarm = v;
            3: usb_wake = v;
            4: supply_monitor_alarm = v;
            default: wake_pins[3] = v;
        endcase
    endtask

    initial begin
        {arst_n, reg_disable, slow_clk_xtal_sel, supply_monitor_alarm, calendar_alarm} = 5'h00;
        {real_time_timer_alarm, usb_wake} = 2'h0;
        {supply_monitor_wake_en, calendar_wake_en, real_time_timer_wake_en, usb_wake_en} = 4'hF;
        {wake_pins, fast_startup_enables} = 32'h0;
        wake_pin_enables  = 16'h0008;
        wake_pin_debounce = 16'h0008;
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(fast_rc_osc_enable & core_clk_en & io_reset_pullup & regulator_ready, 1'b1, "reset");
        chk(in_wait | in_backup | io_hold, 1'b0, "reset state");
        $display("test reset done");
        for (s = 0; s < 3; s++) begin
            i_core_model.set_clk(2'(s));
            @(negedge sys_clk);
            chk(core_clk_source === 2'(s), 1'b1, "clock source");
        end
        reg_disable = 1'b1;
        slow_clk_xtal_sel = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk(regulator_on, 1'b0, "regulator disable");
        chk(core_supply_on & slow_osc_xtal, 1'b1, "slow source");
        reg_disable = 1'b0;
        $display("test active done");
        for (s = 0; s < 4; s++) begin
            i_core_model.sleep(1'b0, n);
            chk(n == 0, 1'b1, "rc flag clear");
            wait_on(0, 1'b1, 10, n);
            chk(n == `RESYNC_CYCLES, 1'b1, "wait entry time");
            chk(core_clk_en | periph_clk_en | mem_clk_en, 1'b0, "wait clocks");
            chk(core_supply_on & sram_supply_on, 1'b1, "wait supplies");
            wake(s, 1'b1);
            wait_on(2, 1'b1, 20, n);
            chk(n <= 6, 1'b1, "wait restart time");
            chk(fast_rc_osc_enable & !in_wait, 1'b1, "rc flag set");
            chk(core_clk_source === `CLKSRC_FAST_RC, 1'b1, "restart source");
            wake(s, 1'b0);
        end
        wake(3, 1'b1);
        i_core_model.sleep(1'b0, n);
        repeat (4) @(negedge sys_clk);
        chk(in_wait | !fast_rc_osc_enable, 1'b0, "pending wake abort");
        wake(3, 1'b0);
        $display("test wait done");
        foreach (bk_src[k]) begin
            i_core_model.sleep(1'b1, n);
            wait_on(1, 1'b1, 10, n);
            chk(n == `RESYNC_CYCLES, 1'b1, "backup entry time");
            chk(regulator_on | core_supply_on | sram_supply_on, 1'b0, "backup off");
            chk(backup_domain_on & io_hold & slow_osc_xtal, 1'b1, "backup kept");
            wake(bk_src[k], 1'b1);
            wait_on(1, 1'b0, 60, n);
            @(negedge sys_clk);
            chk(core_supply_on & sram_supply_on, 1'b1, "supplies back");
            wait_on(3, 1'b1, REG_CYC + 4, n);
            chk(n >= REG_CYC - 2, 1'b1, "regulator start");
            chk(io_reset_pullup & !io_hold, 1'b1, "io after backup");
            wait_on(2, 1'b1, 8, n);
            wake(bk_src[k], 1'b0);
        end
        $display("test backup done");
        summarize();
    end
endmodule // low_power_mode_sequencer_bench
